// [bench/sirp_master.sv]
`timescale 1ns/1ns
module sirp_master (
    input wire logic clk_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_out
);
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end
    task automatic step(input logic c, input int n);
        scl_out <= c;
        repeat (n) @(posedge clk_in);
    endtask : step
    // 5 clocks low covers the slave's output latency, 3 high
    task automatic bit_io(input logic b, output logic s);
        step(1'b0, 2);
        sda_out <= b;
        step(1'b0, 3);
        step(1'b1, 3);
        s = sda_in;
    endtask : bit_io
    task automatic start();
        step(1'b0, 2);
        sda_out <= 1'b1;
        step(1'b0, 3);
        step(1'b1, 3);
        sda_out <= 1'b0;
        step(1'b1, 3);
    endtask : start
    task automatic stop();
        step(1'b0, 2);
        sda_out <= 1'b0;
        step(1'b0, 3);
        step(1'b1, 3);
        sda_out <= 1'b1;
        step(1'b1, 3);
    endtask : stop
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(b[i], s);
        bit_io(1'b1, ack);
    endtask : wbyte
    task automatic rbyte(output logic [7:0] d, input logic last);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(last, s);
    endtask : rbyte
endmodule : sirp_master

// [bench/sirp_port_bench.sv]
`timescale 1ns/1ns
module sirp_port_bench;
    import sirp_pkg::*;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic amb = 1'b0, proximity_channel = 1'b0, s, scl, m_sda, sda, sda_o, sda_oe_n, int_oe_n, busy;
    logic [1:0] irq_en = 2'b00;
    logic [7:0] rdata, status, mem [256];
    logic [31:0] rng = 32'h1afbc295;
    sirp_req_t req;
    int model_mem [256];
    int ptr, stat_m = 4, fail_count = 0, cmp_count = 0;
    always #50 clk_in = ~clk_in;
    // open-drain wire with pull-up
    assign sda = m_sda & (sda_oe_n | sda_o);
    assign rdata = mem[req.addr];
    always @(posedge clk_in) if (req.wr) mem[req.addr] <= req.wdata;
    sirp_port sirp_port_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_o), .sda_oe_n_out(sda_oe_n), .int_oe_n_out(int_oe_n), .irq_enable_in(irq_en),
        .ambient_event_in(amb), .proximity_event_in(proximity_channel), .reg_req_out(req), .reg_rdata_in(rdata),
        .status_out(status), .busy_out(busy));
    sirp_master sirp_master_inst (.clk_in(clk_in), .sda_in(sda), .scl_out(scl), .sda_out(m_sda));
    function automatic logic [7:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng[7:0];
    endfunction : rnd
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic conclude();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude
    task automatic xfer(input logic [7:0] b);
        logic a;
        sirp_master_inst.wbyte(b, a);
        check("ack", {7'h00, a}, 8'h00);
    endtask : xfer
    task automatic put(input logic [7:0] p, input logic [7:0] d);
        sirp_master_inst.start();
        xfer(8'h94);
        xfer(p);
        xfer(d);
        sirp_master_inst.stop();
        model_mem[p] = d;
    endtask : put
    task automatic wr_frame(input logic [7:0] p, input int n);
        logic [7:0] d;
        sirp_master_inst.start();
        xfer(8'h94);
        xfer(p);
        for (ptr = p; n > 0; n--) begin
            d = rnd();
            if (ptr < 256) xfer(d);
            else sirp_master_inst.wbyte(d, s);
            if (ptr < 256) model_mem[ptr] = d;
            ptr = (ptr < 256) ? ptr + 1 : 256;
        end
        sirp_master_inst.stop();
        for (int i = 0; i < 256; i++) check("map", mem[i], model_mem[i][7:0]);
    endtask : wr_frame
    task automatic rd_frame(input bit idx, input logic [7:0] p, input int n);
        logic [7:0] d;
        ptr = idx ? p : 0;
        sirp_master_inst.start();
        if (idx) xfer(8'h94);
        if (idx) xfer(p);
        if (idx) sirp_master_inst.start();
        xfer(8'h95);
        for (int i = 0; i < n; i++) begin
            sirp_master_inst.rbyte(d, i == n - 1);
            check("read", d, ptr > 255 ? 8'hff : ptr == 0 ? stat_m[7:0] : model_mem[ptr][7:0]);
            if (ptr == 0) stat_m = 0;
            ptr = (ptr < 256) ? ptr + 1 : 256;
        end
        sirp_master_inst.stop();
        check("status", status, stat_m[7:0]);
    endtask : rd_frame
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = rnd();
        for (int i = 0; i < 256; i++) model_mem[i] = mem[i];
        repeat (20) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        check("status", status, 8'h04);
        check("int", {7'h00, int_oe_n}, 8'h01);
        sirp_master_inst.start();
        sirp_master_inst.wbyte(8'h96, s);
        check("foreign ack", {7'h00, s}, 8'h01);
        sirp_master_inst.stop();
        put(8'h02, 8'hf0);
        put(8'h01, 8'h13);
        put(8'h0a, 8'h00);
        wr_frame(8'hfd, 4);
        rd_frame(1'b0, 8'h00, 3);
        rd_frame(1'b1, 8'hfe, 3);
        sirp_master_inst.start();
        xfer(8'h94);
        sirp_master_inst.bit_io(1'b0, s);
        sirp_master_inst.stop();
        repeat (2) @(posedge clk_in);
        check("busy", {7'h00, busy}, 8'h00);
        irq_en <= 2'b11;
        @(posedge clk_in);
        amb <= 1'b1;
        @(posedge clk_in);
        amb <= 1'b0;
        proximity_channel <= 1'b1;
        @(posedge clk_in);
        proximity_channel <= 1'b0;
        repeat (3) @(posedge clk_in);
        stat_m = 3;
        check("int", {7'h00, int_oe_n}, 8'h00);
        rd_frame(1'b0, 8'h00, 2);
        check("int", {7'h00, int_oe_n}, 8'h01);
        conclude();
    end
    initial begin
        repeat (20000) @(posedge clk_in);
        fail_count++;
        conclude();
    end
endmodule : sirp_port_bench

// [bench/sirp_port_props.sv]
`timescale 1ns/1ns
module sirp_port_props
    import sirp_pkg::*;
#(
    parameter bit REV1 = 1'b1
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe_n_out,
    input wire logic int_oe_n_out,
    input wire logic [1:0] irq_enable_in,
    input wire logic ambient_event_in,
    input wire sirp_pkg::sirp_req_t reg_req_out,
    input wire logic [7:0] status_out
);
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);
    sequence s_amb_set;
        ambient_event_in && irq_enable_in[0];
    endsequence
    sequence s_flag_up;
        $rose(status_out[0] | status_out[1]);
    endsequence
    property p_open_drain;
        sda_out == 1'b0;
    endproperty
    property p_change_low;
        $changed(sda_oe_n_out) |-> !scl_in && !$past(scl_in);
    endproperty
    // 6 clocks is shorter than any legal bus bit
    property p_ack_hold;
        $fell(sda_oe_n_out) |-> !sda_oe_n_out [*6];
    endproperty
    property p_wr_pulse;
        reg_req_out.wr |=> !reg_req_out.wr;
    endproperty
    property p_event;
        s_amb_set |-> ##[1:2] status_out[0];
    endproperty
    property p_en_clear;
        !irq_enable_in[0] [*3] |-> !status_out[0];
    endproperty
    property p_int_rise;
        s_flag_up |=> !int_oe_n_out;
    endproperty
    property p_int_quiet;
        (REV1 && status_out[1:0] == 2'b00) [*2] |-> int_oe_n_out;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("data pin driven high");
    a_change_low: assert property (p_change_low) else $error("data moved with clock high");
    a_ack_hold: assert property (p_ack_hold) else $error("low drive too short");
    a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe too long");
    a_event: assert property (p_event) else $error("ambient flag not set");
    a_en_clear: assert property (p_en_clear) else $error("disabled flag kept");
    a_int_rise: assert property (p_int_rise) else $error("interrupt not driven");
    a_int_quiet: assert property (p_int_quiet) else $error("interrupt without cause");
endmodule : sirp_port_props

bind sirp_port sirp_port_props #(.REV1(REV1)) sirp_port_props_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .scl_in(scl_in), .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out), .int_oe_n_out(int_oe_n_out),
    .irq_enable_in(irq_enable_in), .ambient_event_in(ambient_event_in), .reg_req_out(reg_req_out),
    .status_out(status_out));

// [design/sirp_port.sv]
// Operation
// R1 - master clocks bus, any rate to 400kHz
// R2 - answer only own write/read address byte
// R3 - eight bits MSB first, ninth acknowledge
// R4 - START/STOP are SDA edges with SCL high
// R5 - data stable while SCL high, sampled then
// R6 - STOP anywhere aborts, except START's pulse
// R7 - master never STOPs in START's pulse
// R8 - hold SDA low through ninth received pulse
// R9 - write: address, pointer byte, data, STOP
// R10 - pointer advances after each written byte
// R11 - read after START zeros pointer unless preset
// R12 - pointer advances after each transmitted byte
// R13 - after STOP, plain read starts at zero
// R14 - preset pointer then repeated START reads it
// R15 - past top of map returns 0xFF
// R16 - master acks all but last, then NACK
// R17 - change SDA only while SCL low
// R18 - SDA open-drain only, SCL input only
// R19 - repeated START decodes fresh address byte
// R20 - reading status register clears the interrupt
// R21 - first revision power-on flag stays silent
// R22 - host writes F0 to register 0x02
// R23 - host writes 0x13 to register 0x01
// R24 - first revision host leaves 0x0A zero
`timescale 1ns/1ns
module sirp_port #(
    parameter bit REV1 = 1'b1
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n_out,
    output logic int_oe_n_out,
    input wire logic [1:0] irq_enable_in,
    input wire logic ambient_event_in,
    input wire logic proximity_event_in,
    output sirp_pkg::sirp_req_t reg_req_out,
    input wire logic [7:0] reg_rdata_in,
    output logic [7:0] status_out,
    output logic busy_out
);
    import sirp_pkg::*;

    sirp_lines_t sync1;
    sirp_lines_t sync2;
    sirp_lines_t prev;

    sirp_state_t state;
    logic [7:0] shift;
    logic [3:0] bit_cnt;
    logic in_ack;
    logic master_ack;
    logic read_ack;
    logic preset;
    logic start_pulse;
    logic [PTR_W-1:0] ptr;
    logic [7:0] tx;
    logic fetch_go;
    logic fetch_wait;
    logic status_clr;
    logic [7:0] clr_mask;
    logic [7:0] status;
    wire logic [2:0] flags;
    logic [2:0] flag_en;
    logic [2:0] flag_evt;
    logic [7:0] next_tx;
    logic next_clr;
    logic int_cause;

    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic [PTR_W-1:0] ptr_inc;

    // two flops before anything looks at the pins
    // the pins are unrelated to clk_in, one flop alone could go metastable
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            sync1 <= '{scl: 1'b1, sda: 1'b1};
            sync2 <= '{scl: 1'b1, sda: 1'b1};
            prev <= '{scl: 1'b1, sda: 1'b1};
        end else begin
            sync1 <= '{scl: scl_in, sda: sda_in}; // [R18]
            sync2 <= sync1;
            prev <= sync2;
        end
    end

    // any SCL rate works as long as each low phase lasts 5 clocks
    assign scl_rise = sync2.scl && !prev.scl; // [R1]
    assign scl_fall = !sync2.scl && prev.scl;
    assign start_det = sync2.scl && prev.scl && prev.sda && !sync2.sda; // [R4]
    assign stop_det = sync2.scl && prev.scl && !prev.sda && sync2.sda; // [R4]
    // saturate past the top so a long read keeps answering 0xFF
    assign ptr_inc = ptr[PTR_W-1] ? ptr : ptr + 9'h001; // [R15]

    // marks the SCL high pulse that carried a START
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            start_pulse <= 1'b0;
        end else if (start_det) begin
            start_pulse <= 1'b1;
        end else if (scl_fall) begin
            start_pulse <= 1'b0;
        end
    end

    // bit framing and protocol state
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            state <= ST_IDLE;
            shift <= 8'h00;
            bit_cnt <= 4'h0;
            in_ack <= 1'b0;
            master_ack <= 1'b0;
            read_ack <= 1'b0;
            preset <= 1'b0;
            ptr <= PTR_RESET;
            sda_oe_n_out <= 1'b1;
            fetch_go <= 1'b0;
            reg_req_out <= '0;
        end else begin
            fetch_go <= 1'b0;
            reg_req_out.wr <= 1'b0;
            reg_req_out.rd <= fetch_go;
            if (fetch_go) begin
                reg_req_out.addr <= ptr[7:0];
            end
            if (start_det) begin
                // repeated START keeps the preset pointer
                state <= ST_ADDR; // [R19]
                bit_cnt <= 4'h0;
                in_ack <= 1'b0;
                read_ack <= 1'b0;
                master_ack <= 1'b0;
                sda_oe_n_out <= 1'b1;
            end else if (stop_det && !start_pulse) begin
                state <= ST_IDLE; // [R6]
                preset <= 1'b0; // [R13]
                in_ack <= 1'b0;
                bit_cnt <= 4'h0;
                read_ack <= 1'b0;
                master_ack <= 1'b0;
                sda_oe_n_out <= 1'b1;
            end else if (state != ST_IDLE) begin
                if (scl_rise) begin
                    if (bit_cnt < BYTE_BITS) begin
                        shift <= {shift[6:0], sync2.sda}; // [R3] [R5]
                        bit_cnt <= bit_cnt + 4'h1;
                    end else begin
                        master_ack <= !sync2.sda; // [R16]
                    end
                end
                if (scl_fall) begin
                    if (bit_cnt == BYTE_BITS && !in_ack) begin
                        in_ack <= 1'b1;
                        sda_oe_n_out <= 1'b1;
                        case (state)
                            ST_ADDR: begin
                                if (shift[7:1] == DEV_ADDR) begin // [R2]
                                    sda_oe_n_out <= 1'b0; // [R8]
                                    if (shift[0] == DIR_READ) begin
                                        if (!preset) begin
                                            ptr <= PTR_RESET; // [R11] [R13]
                                        end
                                        preset <= 1'b0;
                                        read_ack <= 1'b1;
                                        fetch_go <= 1'b1; // [R14]
                                        state <= ST_RDATA;
                                    end else begin
                                        state <= ST_PTR; // [R9]
                                    end
                                end else begin
                                    state <= ST_IDLE;
                                end
                            end
                            ST_PTR: begin
                                sda_oe_n_out <= 1'b0; // [R8]
                                ptr <= {1'b0, shift}; // [R9]
                                preset <= 1'b1;
                                state <= ST_WDATA;
                            end
                            ST_WDATA: begin
                                sda_oe_n_out <= 1'b0; // [R8]
                                reg_req_out.wr <= !ptr[PTR_W-1];
                                reg_req_out.addr <= ptr[7:0];
                                reg_req_out.wdata <= shift;
                                ptr <= ptr_inc; // [R10]
                                preset <= 1'b0;
                            end
                            ST_RDATA: begin
                                read_ack <= 1'b0;
                                ptr <= ptr_inc; // [R12]
                                fetch_go <= 1'b1;
                            end
                            default: begin
                                state <= ST_IDLE;
                            end
                        endcase
                    end else if (in_ack) begin
                        in_ack <= 1'b0;
                        bit_cnt <= 4'h0;
                        sda_oe_n_out <= 1'b1;
                        if (state == ST_RDATA) begin
                            if (read_ack || master_ack) begin
                                // first bit goes out while SCL is low
                                sda_oe_n_out <= tx[7]; // [R17]
                            end else begin
                                // NACK: stay silent until the next condition
                                state <= ST_IDLE; // [R16]
                            end
                        end
                    end else if (state == ST_RDATA && bit_cnt != 4'h0) begin
                        sda_oe_n_out <= tx[3'(4'h7 - bit_cnt)]; // [R3] [R17]
                    end
                end
            end
        end
    end

    // fetched byte lands one cycle after the read strobe
    always_comb begin
        next_tx = reg_rdata_in;
        next_clr = 1'b0;
        if (ptr[PTR_W-1]) begin
            next_tx = PAST_TOP_DATA; // [R15]
        end else if (ptr[7:0] == STATUS_ADDR) begin
            // status lives here, so the map's copy is never used
            next_tx = status;
            next_clr = 1'b1; // [R20]
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            fetch_wait <= 1'b0;
            tx <= PAST_TOP_DATA;
            status_clr <= 1'b0;
            clr_mask <= 8'h00;
        end else begin
            fetch_wait <= fetch_go;
            status_clr <= fetch_wait && next_clr; // [R20]
            if (fetch_wait) begin
                tx <= next_tx;
                // only bits latched into the outgoing byte are cleared, later events survive
                clr_mask <= status;
            end
        end
    end

    // per-bit enables and events, indexed by the status layout
    always_comb begin
        flag_en = 3'b111;
        flag_evt = 3'b000;
        flag_en[STAT_AMBIENT_BIT] = irq_enable_in[0];
        flag_en[STAT_PROXIMITY_BIT] = irq_enable_in[1];
        flag_evt[STAT_AMBIENT_BIT] = ambient_event_in;
        flag_evt[STAT_PROXIMITY_BIT] = proximity_event_in;
    end

    // sticky interrupt status; a new event beats a clear in the same cycle
    for (genvar i = 0; i < 3; i++) begin : g_flag
        sirp_flag sirp_flag_inst (
            .clk_in(clk_in),
            .sys_rst_in(sys_rst_in),
            .rst_val_in(STATUS_RESET[i]),
            .enable_in(flag_en[i]),
            .event_in(flag_evt[i]),
            .clear_in(status_clr && clr_mask[i]), // [R20]
            .flag_out(flags[i])
        );
    end

    assign status = {5'h00, flags};

    // power-on flag only reaches the pin on later revisions
    assign int_cause = status[STAT_AMBIENT_BIT] || status[STAT_PROXIMITY_BIT]
        || (!REV1 && status[STAT_POWER_ON_BIT]); // [R21]

    // interrupt pin, open-drain: low enable pulls it low
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            int_oe_n_out <= 1'b1;
        end else begin
            int_oe_n_out <= !int_cause; // [R20]
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            busy_out <= 1'b0;
        end else begin
            busy_out <= (state != ST_IDLE);
        end
    end

    // only ever pulls low
    assign sda_out = 1'b0; // [R18]
    assign status_out = status;

endmodule : sirp_port

// one sticky status bit: disable wins, then event, then read clear
module sirp_flag (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic rst_val_in,
    input wire logic enable_in,
    input wire logic event_in,
    input wire logic clear_in,
    output logic flag_out
);

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            flag_out <= rst_val_in;
        end else if (!enable_in) begin
            flag_out <= 1'b0;
        end else if (event_in) begin
            // an event in the clearing cycle must not be lost
            flag_out <= 1'b1;
        end else if (clear_in) begin
            flag_out <= 1'b0;
        end
    end

endmodule : sirp_flag

// [pkg/sirp_pkg.sv]
package sirp_pkg;

    // clock and bus timing
    localparam int CLK_KHZ = 10000;
    localparam int SCL_MAX_KHZ = 400;
    localparam int SCL_MIN_PERIOD_CYC = CLK_KHZ / SCL_MAX_KHZ;

    // byte framing
    localparam logic [3:0] BYTE_BITS = 4'h8;

    // 7-bit bus address, direction bit appended on the wire
    localparam logic [6:0] DEV_ADDR = 7'h4a;
    localparam logic DIR_WRITE = 1'b0;
    localparam logic DIR_READ = 1'b1;

    // pointer and map limits
    localparam int PTR_W = 9;
    localparam logic [8:0] PTR_RESET = 9'h000;
    localparam logic [7:0] PAST_TOP_DATA = 8'hff;
    localparam logic [7:0] STATUS_ADDR = 8'h00;
    localparam logic [7:0] RESERVED_FIRST = 8'hf6;

    // interrupt status layout
    localparam int STAT_AMBIENT_BIT = 0;
    localparam int STAT_PROXIMITY_BIT = 1;
    localparam int STAT_POWER_ON_BIT = 2;
    localparam logic [7:0] STATUS_RESET = 8'h04;

    typedef struct packed {
        logic scl;
        logic sda;
    } sirp_lines_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sirp_req_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_PTR,
        ST_WDATA,
        ST_RDATA
    } sirp_state_t;

endpackage : sirp_pkg
